/* File: hdl/wor_pkg.sv */
// Purpose: constants for the wake-on-radio event timer
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes:   register offsets are the printed byte addresses
package wor_pkg;
   localparam logic [7:0] WOR_ADDR_HIGH = 8'h1E;
   localparam logic [7:0] WOR_ADDR_LOW  = 8'h1F;
   localparam logic [7:0] WOR_ADDR_CTRL = 8'h20;
   localparam logic [7:0] WOR_RST_HIGH  = 8'h87;
   localparam logic [7:0] WOR_RST_LOW   = 8'h6B;
   localparam logic [7:0] WOR_RST_CTRL  = 8'hF8;
   localparam logic [7:0] WOR_CTRL_MASK = 8'hFB;
   localparam int         WOR_PD_BIT    = 7;
   localparam int         WOR_DLY_MSB   = 6;
   localparam int         WOR_DLY_LSB   = 4;
   localparam int         WOR_CAL_BIT   = 3;
   localparam int         WAKE_TIMER_RESOLUTION_MSB   = 1;
   localparam int         WOR_XOSC_DIV  = 750;
   localparam int         WAKE_TIMER_RESOLUTION_SHIFT = 5;
   localparam int         WOR_SYNC_MUL  = 2;
   localparam int         WOR_CAL_CYC   = 8;
   localparam logic [7:0] WOR_DLY_C0    = 8'h04;
   localparam logic [7:0] WOR_DLY_C1    = 8'h06;
   localparam logic [7:0] WOR_DLY_C2    = 8'h08;
   localparam logic [7:0] WOR_DLY_C3    = 8'h0C;
   localparam logic [7:0] WOR_DLY_C4    = 8'h10;
   localparam logic [7:0] WOR_DLY_C5    = 8'h18;
   localparam logic [7:0] WOR_DLY_C6    = 8'h20;
   localparam logic [7:0] WOR_DLY_C7    = 8'h30;
endpackage

/* File: hdl/wor_timer.sv */
// Purpose: wake-on-radio event timer with register port
// Assumes: SYS_CLK_I is the crystal reference; inputs synchronous
// Notes:   wake tick is a one-cycle enable every XOSC_DIV clocks
module wor_timer #(
   parameter int XOSC_DIV = wor_pkg::WOR_XOSC_DIV,
   parameter int CAL_CYC  = wor_pkg::WOR_CAL_CYC
) (
   input  wire logic       SYS_CLK_I,
   input  wire logic       RESET_I,
   input  wire logic       REG_WR_I,
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic [7:0] REG_WDATA_I,
   input  wire logic       WAKE_AUTO_SYNC_I,
   output logic      [7:0] REG_RDATA_O,
   output logic            RC_TICK_O,
   output logic            FIRST_EVENT_O,
   output logic            SECOND_EVENT_O,
   output logic            RC_OSC_CAL_ENABLE_BUSY_O
);
   import wor_pkg::*;

   typedef enum logic [1:0] {
      WOR_OFF  = 2'b00,
      WOR_CAL  = 2'b01,
      WOR_RUN  = 2'b10
   } wor_state_e;

   logic [7:0]  wake_timeout_high;
   logic [7:0]  wake_timeout_low;
   logic [7:0]  wake_control;
   wor_state_e  state;
   logic [9:0]  div_cnt;
   logic [3:0]  cal_cnt;
   logic [30:0] step_cnt;
   logic [15:0] evt_cnt;
   logic [7:0]  dly_cnt;
   logic        dly_run;
   logic [7:0]  next_delay;
   logic [30:0] step_len;
   logic [15:0] timeout;

   assign timeout = {wake_timeout_high, wake_timeout_low};

   ////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         wake_timeout_high <= WOR_RST_HIGH;
         wake_timeout_low  <= WOR_RST_LOW;
         wake_control      <= WOR_RST_CTRL;
      end else if (REG_WR_I) begin
         case (REG_ADDR_I)
            WOR_ADDR_HIGH: wake_timeout_high <= REG_WDATA_I;
            WOR_ADDR_LOW:  wake_timeout_low  <= REG_WDATA_I;
            WOR_ADDR_CTRL: wake_control <= REG_WDATA_I & WOR_CTRL_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I)
         REG_RDATA_O <= 8'h00;
      else begin
         case (REG_ADDR_I)
            WOR_ADDR_HIGH: REG_RDATA_O <= wake_timeout_high;
            WOR_ADDR_LOW:  REG_RDATA_O <= wake_timeout_low;
            WOR_ADDR_CTRL: REG_RDATA_O <= wake_control;
            default:       REG_RDATA_O <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Oscillator power and calibration
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         state   <= WOR_OFF;
         cal_cnt <= 4'h0;
      end else if (wake_control[WOR_PD_BIT]) begin
         state   <= WOR_OFF;
         cal_cnt <= 4'h0;
      end else begin
         case (state)
            WOR_OFF: begin
               cal_cnt <= 4'h0;
               if (wake_control[WOR_CAL_BIT])
                  state <= WOR_CAL;
               else
                  state <= WOR_RUN;
            end
            WOR_CAL: begin
               cal_cnt <= cal_cnt + 4'h1;
               if (cal_cnt == 4'(CAL_CYC - 1))
                  state <= WOR_RUN;
            end
            WOR_RUN: state <= WOR_RUN;
            default: state <= WOR_OFF;
         endcase
      end
   end
   assign RC_OSC_CAL_ENABLE_BUSY_O = (state == WOR_CAL);

   ////////////////////////////////////////////////////////////////////
   // Wake tick: crystal divided by XOSC_DIV
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I || state != WOR_RUN) begin
         div_cnt   <= 10'h000;
         RC_TICK_O <= 1'b0;
      end else if (div_cnt == 10'(XOSC_DIV - 1)) begin
         div_cnt   <= 10'h000;
         RC_TICK_O <= 1'b1;
      end else begin
         div_cnt   <= div_cnt + 10'h001;
         RC_TICK_O <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Event 0: timeout times 2^(5*res) ticks
   always_comb begin
      step_len = 31'h1 << (WAKE_TIMER_RESOLUTION_SHIFT * wake_control[WAKE_TIMER_RESOLUTION_MSB:0]);
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I || state != WOR_RUN) begin
         step_cnt      <= 31'h0;
         evt_cnt       <= 16'h0;
         FIRST_EVENT_O <= 1'b0;
      end else begin
         FIRST_EVENT_O <= 1'b0;
         if (RC_TICK_O) begin
            if (step_cnt >= step_len - 31'h1) begin
               step_cnt <= 31'h0;
               if (evt_cnt >= timeout - 16'h1) begin
                  evt_cnt       <= 16'h0;
                  FIRST_EVENT_O <= 1'b1;
               end else
                  evt_cnt <= evt_cnt + 16'h1;
            end else
               step_cnt <= step_cnt + 31'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Event 1 delay decode
   always_comb begin
      case (wake_control[WOR_DLY_MSB:WOR_DLY_LSB])
         3'h0:    next_delay = WOR_DLY_C0;
         3'h1:    next_delay = WOR_DLY_C1;
         3'h2:    next_delay = WOR_DLY_C2;
         3'h3:    next_delay = WOR_DLY_C3;
         3'h4:    next_delay = WOR_DLY_C4;
         3'h5:    next_delay = WOR_DLY_C5;
         3'h6:    next_delay = WOR_DLY_C6;
         default: next_delay = WOR_DLY_C7;
      endcase
      if (WAKE_AUTO_SYNC_I)
         next_delay = next_delay << WOR_SYNC_MUL;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I || state != WOR_RUN) begin
         dly_cnt        <= 8'h00;
         dly_run        <= 1'b0;
         SECOND_EVENT_O <= 1'b0;
      end else begin
         SECOND_EVENT_O <= 1'b0;
         if (FIRST_EVENT_O) begin
            dly_cnt <= next_delay;
            dly_run <= 1'b1;
         end else if (dly_run && RC_TICK_O) begin
            if (dly_cnt == 8'h01) begin
               dly_run        <= 1'b0;
               SECOND_EVENT_O <= 1'b1;
            end
            dly_cnt <= dly_cnt - 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_first_taken;
      FIRST_EVENT_O && state == WOR_RUN;
   endsequence

   sequence s_delay_last;
      dly_run && RC_TICK_O && dly_cnt == 8'h01
      && !FIRST_EVENT_O && state == WOR_RUN;
   endsequence

   sequence s_cal_last;
      state == WOR_CAL && cal_cnt == 4'(CAL_CYC - 1)
      && !wake_control[WOR_PD_BIT];
   endsequence

   a_pd_holds_off: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      wake_control[WOR_PD_BIT] |=> state == WOR_OFF)
      else $error("powerdown did not stop oscillator");
   a_tick_spacing: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      RC_TICK_O |=> !RC_TICK_O)
      else $error("wake tick not a pulse");
   a_cal_start: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      (state == WOR_OFF && !wake_control[WOR_PD_BIT]
       && wake_control[WOR_CAL_BIT]) |=> state == WOR_CAL)
      else $error("calibration not launched");
   a_cal_end: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      s_cal_last |=> state == WOR_RUN)
      else $error("calibration did not hand over to run");
   a_dly_load: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      s_first_taken |=> dly_run && dly_cnt == $past(next_delay))
      else $error("delay not started after first event");
   a_second_fire: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      s_delay_last |=> SECOND_EVENT_O)
      else $error("second event missing after delay");
   a_second_after: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      SECOND_EVENT_O |-> $past(dly_run) && $past(dly_cnt) == 8'h01)
      else $error("second event without expired delay");
   a_first_zero: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      FIRST_EVENT_O |-> $past(RC_TICK_O))
      else $error("first event without tick");
   a_reg_high: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      (REG_WR_I && REG_ADDR_I == WOR_ADDR_HIGH)
      |=> wake_timeout_high == $past(REG_WDATA_I))
      else $error("high byte write lost");
   a_reg_low: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      (REG_WR_I && REG_ADDR_I == WOR_ADDR_LOW)
      |=> wake_timeout_low == $past(REG_WDATA_I))
      else $error("low byte write lost");
   a_reset_values: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      $fell(RESET_I) |-> timeout == {WOR_RST_HIGH, WOR_RST_LOW}
      && wake_control == WOR_RST_CTRL)
      else $error("registers not at reset values");
   a_res_coarse: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      wake_control[WAKE_TIMER_RESOLUTION_MSB:0] == 2'h3 |-> step_len == 31'h0000_8000)
      else $error("coarsest resolution step wrong");
   a_dly_top: assert property (
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      (wake_control[WOR_DLY_MSB:WOR_DLY_LSB] == 3'h7 && WAKE_AUTO_SYNC_I)
      |-> next_delay == 8'hC0)
      else $error("longest synced delay wrong");
endmodule

/* File: testbench/tb_wor_timer.sv */
// Purpose: self-checking bench for the wake event timer
// Assumes: XOSC_DIV shortened to 4, calibration 8 clocks
// Notes:   inputs driven and outputs read at falling edge
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wor_pkg::*;
   localparam int DIV = 4;
   logic       clk;
   logic       rst;
   logic       wr;
   logic [7:0] addr;
   logic [7:0] wd;
   logic       sync;
   logic [7:0] rd;
   logic       tick;
   logic       ev0;
   logic       ev1;
   logic       busy;
   int         failures;
   int         cmp_count;
   int         dly [8] = '{4, 6, 8, 12, 16, 24, 32, 48};
   int         tmo [3] = '{200, 2, 1};

   wor_timer #(.XOSC_DIV(DIV), .CAL_CYC(WOR_CAL_CYC)) u_wor_timer (
      .SYS_CLK_I       (clk),
      .RESET_I         (rst),
      .REG_WR_I        (wr),
      .REG_ADDR_I      (addr),
      .REG_WDATA_I     (wd),
      .WAKE_AUTO_SYNC_I(sync),
      .REG_RDATA_O     (rd),
      .RC_TICK_O       (tick),
      .FIRST_EVENT_O   (ev0),
      .SECOND_EVENT_O  (ev1),
      .RC_OSC_CAL_ENABLE_BUSY_O   (busy)
   );

   ////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] s,
                        input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      check("read data", 16'(rd), 16'(e));
   endtask

   // Stop, clear, then restart with calibration off
   task automatic start(input logic [7:0] c);
      reg_wr(WOR_ADDR_CTRL, 8'hF8);
      reg_wr(WOR_ADDR_CTRL, c);
   endtask

   // Cycles until the chosen pulse, bounded
   task automatic gap(input int sel, output int n);
      logic s;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         s = (sel == 0) ? ev0 : (sel == 1) ? ev1 : tick;
      end while (s !== 1'b1 && n < 5000);
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk(WOR_ADDR_HIGH, 8'h87);
      rd_chk(WOR_ADDR_LOW, 8'h6B);
      rd_chk(WOR_ADDR_CTRL, 8'hF8);
      reg_wr(WOR_ADDR_CTRL, 8'hFF);
      rd_chk(WOR_ADDR_CTRL, 8'hFB);
      reg_wr(8'h21, 8'h5A);
      rd_chk(8'h21, 8'h00);
      reg_wr(WOR_ADDR_HIGH, 8'h00);
      reg_wr(WOR_ADDR_LOW, 8'hC8);
      rd_chk(WOR_ADDR_LOW, 8'hC8);
      rd_chk(WOR_ADDR_HIGH, 8'h00);
   endtask

   task automatic t_delay();
      int n;
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 8; c++) begin
            sync = s[0];
            start({1'b0, c[2:0], 4'h0});
            gap(0, n);
            gap(1, n);
            check("delay", 16'(n), 16'(dly[c] * DIV << (2 * s)));
         end
      end
   endtask

   task automatic t_period();
      int n;
      for (int r = 0; r < 3; r++) begin
         reg_wr(WOR_ADDR_LOW, 8'(tmo[r]));
         start({6'h1C, r[1:0]});
         gap(0, n);
         gap(0, n);
         check("period", 16'(n), 16'(tmo[r] * DIV << (5 * r)));
         gap(0, n);
         check("period again", 16'(n), 16'(tmo[r] * DIV << (5 * r)));
      end
      // Coarsest step: no event within the bounded wait
      start(8'h73);
      gap(0, n);
      check("coarse step", 16'(n), 16'h1388);
      gap(2, n);
      gap(2, n);
      check("tick gap", 16'(n), 16'(DIV));
   endtask

   task automatic t_cal();
      int n;
      logic any;
      reg_wr(WOR_ADDR_CTRL, 8'hF8);
      reg_wr(WOR_ADDR_CTRL, 8'h78);
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("cal busy", 16'(n), 16'(WOR_CAL_CYC));
      reg_wr(WOR_ADDR_CTRL, 8'hF8);
      @(negedge clk);
      any = 1'b0;
      repeat (300) begin
         @(negedge clk);
         any = any | tick | ev0 | ev1;
      end
      check("stopped", 16'(any), 16'h0000);
   endtask

   task automatic give_verdict();
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      failures = 0;
      cmp_count = 0;
      rst = 1'b1;
      wr = 1'b0;
      addr = 8'h00;
      wd = 8'h00;
      sync = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_delay();
      t_period();
      t_cal();
      give_verdict();
   end

   initial begin
      #1500000;
      failures++;
      give_verdict();
   end
endmodule
